// [rtl/error_group_pkg.sv]
// Purpose: constants for the error group discovery register bank
// Assumes: 32-bit register port, byte addresses inside one 4KB page
// Notes:   64-bit registers are two words, low word at the lower address
//
// Summary of operation
// RL1: architecture discovery word always present, read-only, at its fixed offset.
// RL2: architect field is continuation code over seven-bit id code, a constant.
// RL3: bit 20 of architecture discovery always reads one.
// RL4: revision field reads 0 for v1.0 or 1 for v1.1 only.
// RL5: version field reads zero; part field is a fixed constant.
// RL6: record count word is read-only, upper half zero, low half highest index plus one.
// RL7: record count never exceeds fifty-six in one page.
// RL8: group summary is 64-bit read-only with top eight bits zero.
// RL9: summary bit m mirrors valid bit of record m.
// RL10: summary bit reads zero for absent or non-reporting records.
// RL11: identity word is read-only; all zero means not implemented.
// RL12: identity bits 31..20 carry the part number.
// RL13: identity bits 19..16 major, 15..12 minor revision.
// RL14: identity bits 11..8 bank minus one, 6..0 maker code, bit 7 zero.
// RL15: sixteen 64-bit read/write config slots at eight-byte spacing, absent ones zero.
// RL16: slots 0-1 fault, 2-3 recovery, 4-5 critical, slot 15 status.
// RL17: interrupt status is 64 bits, bits 63..6 read zero.
// RL18: critical write error sets, stays until one written; v1.1 only.
// RL19: critical write busy flag is read-only, high during the write.
// RL20: bits 3,1 write-one-to-clear error flags; bits 2,0 read-only busy flags.
// RL21: software keeps an interrupt enabled while its write is in progress.
// RL22: writes to read-only words ignored; reserved bits read zero.
package error_group_pkg;
   localparam int unsigned   ADDR_W         = 12;
   localparam int unsigned   DATA_W         = 32;
   localparam int unsigned   NUM_IRQ        = 3;
   localparam int unsigned   NUM_SLOTS      = 16;
   localparam int unsigned   NUM_CFG_SLOTS  = 6;
   localparam int unsigned   MAX_RECORDS    = 56;
   localparam logic [11:0]   OFF_SUMMARY    = 12'he00;
   localparam logic [11:0]   OFF_IDENTITY   = 12'he10;
   localparam logic [11:0]   OFF_SLOT_BASE  = 12'he80;
   localparam logic [11:0]   OFF_IRQ_STATUS = 12'hef8;
   localparam logic [11:0]   OFF_ARCH       = 12'hfbc;
   localparam logic [11:0]   OFF_COUNT      = 12'hfc8;
   localparam logic [11:0]   HIGH_WORD      = 12'h004;
   localparam int unsigned   SLOT_STRIDE    = 8;
   localparam int unsigned   STATUS_SLOT    = 15;
   // field positions
   localparam int unsigned   ARCH_ARCHITECT_LSB = 21;
   localparam int unsigned   ARCH_PRESENT_BIT   = 20;
   localparam int unsigned   ARCH_REVISION_LSB  = 16;
   localparam int unsigned   ARCH_VERSION_LSB   = 12;
   localparam int unsigned   ID_PART_LSB        = 20;
   localparam int unsigned   ID_MAJOR_LSB       = 16;
   localparam int unsigned   ID_MINOR_LSB       = 12;
   localparam int unsigned   ID_BANK_LSB        = 8;
   localparam int unsigned   STATUS_USED_BITS   = 6;
   // constant field values
   localparam logic [3:0]    REV_V10            = 4'h0;
   localparam logic [3:0]    REV_V11            = 4'h1;
   localparam logic [3:0]    ARCH_VERSION       = 4'h0;
   // interrupt order: busy flag at bit 2*i, error flag at 2*i+1
   localparam int unsigned   IRQ_FAULT          = 0;
   localparam int unsigned   IRQ_RECOVERY       = 1;
   localparam int unsigned   IRQ_CRITICAL       = 2;
   // reset values
   localparam logic [63:0]   CFG_RESET          = 64'h0;
   localparam logic [2:0]    FLAG_RESET         = 3'h0;
   localparam logic [31:0]   RDATA_RESET        = 32'h0;
endpackage

// [rtl/irq_status_if.sv]
`timescale 1ns/1ps
// Purpose: carries interrupt write progress between the bank and its tracker
// Assumes: one bit per interrupt, fault/recovery/critical order
// Notes:   clear is a one-cycle pulse from a status write
interface irq_status_if;
   logic [2:0] busy_in;
   logic [2:0] err_event;
   logic [2:0] clear;
   logic [2:0] busy_flag;
   logic [2:0] err_flag;
   modport bank    (output busy_in, output err_event, output clear,
                    input busy_flag, input err_flag);
   modport tracker (input busy_in, input err_event, input clear,
                    output busy_flag, output err_flag);
endinterface

// [rtl/irq_write_tracker.sv]
`timescale 1ns/1ps
// Purpose: sticky error flags and registered busy flags of the interrupt message writes
// Assumes: error events are one-cycle pulses from the message writer
// Notes:   critical flags exist only when the v1.1 layout is built
module irq_write_tracker
   import error_group_pkg::*;
#(
   parameter bit CRIT_PRESENT = 1'b1
) (
   input wire logic      mclk,
   input wire logic      nrst,
   irq_status_if.tracker st
);
   typedef struct packed {
      logic [2:0] err;
      logic [2:0] busy;
   } state_type;

   state_type state;
   state_type next_state;
   logic [2:0] keep;

   assign keep = CRIT_PRESENT ? 3'h7 : 3'h3;

   always_comb begin
      next_state = state;
      // set beats clear so an error in the clearing cycle survives
      next_state.err  = ((state.err & ~st.clear) | st.err_event) & keep; // RL18 RL20
      next_state.busy = st.busy_in & keep; // RL19 RL20
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= '{err: FLAG_RESET, busy: FLAG_RESET};
      end else begin
         state <= next_state;
      end
   end

   assign st.err_flag  = state.err;
   assign st.busy_flag = state.busy;

   a_err_sticky: assert property (@(posedge mclk) disable iff (!nrst) // RL18
      (state.err[IRQ_FAULT] && !st.clear[IRQ_FAULT]) |=> state.err[IRQ_FAULT])
      else $error("fault error flag dropped without a clear");
   a_err_set_wins: assert property (@(posedge mclk) disable iff (!nrst) // RL20
      (st.err_event[IRQ_FAULT] && st.clear[IRQ_FAULT]) |=> state.err[IRQ_FAULT])
      else $error("fault error lost against clear");
endmodule

// [rtl/error_group_regs.sv]
`timescale 1ns/1ps
// Purpose: group-level discovery, summary and interrupt slot registers
// Assumes: req is a one-cycle access; addr is a byte address in the page
// Notes:   every access answers ack one cycle later with registered rdata
module error_group_regs
   import error_group_pkg::*;
#(
   parameter int unsigned  NUM_RECORDS   = 56,
   parameter logic [55:0]  SUMMARY_MASK  = {56{1'b1}},
   parameter logic [3:0]   ARCH_REVISION = 4'h1,
   parameter logic [10:0]  ARCHITECT     = 11'h015,  // arbitrary value
   parameter logic [11:0]  ARCH_PART     = 12'h0a5,  // arbitrary value
   parameter bit           ID_PRESENT    = 1'b1,
   parameter logic [11:0]  PART_NUMBER   = 12'h123,  // arbitrary value
   parameter logic [3:0]   ID_MAJOR      = 4'h0,
   parameter logic [3:0]   ID_MINOR      = 4'h0,
   parameter logic [3:0]   MAKER_BANK    = 4'h1,     // arbitrary value
   parameter logic [6:0]   MAKER_CODE    = 7'h25     // arbitrary value
) (
   input  wire logic                                mclk,
   input  wire logic                                nrst,
   input  wire logic                                req,
   input  wire logic                                wr,
   input  wire logic [error_group_pkg::ADDR_W-1:0]  addr,
   input  wire logic [error_group_pkg::DATA_W-1:0]  wdata,
   output      logic                                ack,
   output      logic [error_group_pkg::DATA_W-1:0]  rdata,
   input  wire logic [55:0]                         record_valid,
   input  wire logic [2:0]                          irq_write_busy,
   input  wire logic [2:0]                          irq_write_error,
   output      logic [error_group_pkg::NUM_CFG_SLOTS*64-1:0] irq_config
);
   import error_group_pkg::*;

   // ============================================================
   // elaboration checks
   initial begin
      if (NUM_RECORDS > MAX_RECORDS) begin
         $error("record count above one page"); // RL7
      end
      if (ARCH_REVISION != REV_V10 && ARCH_REVISION != REV_V11) begin
         $error("reserved architecture revision"); // RL4
      end
   end

   localparam bit            V11         = (ARCH_REVISION == REV_V11);
   localparam logic [56:0]   COUNT_ONES  = (57'h1 << NUM_RECORDS) - 57'h1;
   localparam logic [55:0]   REPORT_MASK = SUMMARY_MASK & COUNT_ONES[55:0];
   localparam logic [31:0]   ARCH_WORD   = {ARCHITECT, 1'b1, ARCH_REVISION,
                                            ARCH_VERSION, ARCH_PART};
   localparam logic [31:0]   COUNT_WORD  = {16'h0, 16'(NUM_RECORDS)};
   localparam logic [31:0]   ID_WORD     = ID_PRESENT ?
      {PART_NUMBER, ID_MAJOR, ID_MINOR, MAKER_BANK, 1'b0, MAKER_CODE} : 32'h0;

   // ============================================================
   // state
   typedef struct packed {
      logic [NUM_CFG_SLOTS-1:0][63:0] cfg;
      logic [31:0]                    rdata;
      logic                           ack;
   } state_type;

   state_type    state;
   state_type    next_state;
   irq_status_if st ();
   logic [55:0]  summary;
   logic [5:0]   status_bits;
   logic [4:0]   slot_hit;

   // {hit, index} of the interrupt slot covering an address
   function automatic logic [4:0] slot_of(input logic [11:0] a);
      logic [11:0] rel;
      rel = a - OFF_SLOT_BASE;
      if (a >= OFF_SLOT_BASE && rel < 12'(NUM_SLOTS * SLOT_STRIDE)) begin
         slot_of = {1'b1, rel[6:3]};
      end else begin
         slot_of = 5'h0;
      end
   endfunction

   assign slot_hit = slot_of(addr);
   assign summary  = record_valid & REPORT_MASK; // RL9 RL10

   // ============================================================
   // interrupt write tracking
   assign st.busy_in   = irq_write_busy;
   assign st.err_event = irq_write_error;
   // write-one-to-clear on the odd status bits
   assign st.clear     = (req && wr && addr == OFF_IRQ_STATUS) ?
                         {wdata[2*IRQ_CRITICAL+1], wdata[2*IRQ_RECOVERY+1],
                          wdata[2*IRQ_FAULT+1]} : 3'h0; // RL20 RL18

   irq_write_tracker #(
      .CRIT_PRESENT (V11)
   ) u_tracker (
      .mclk (mclk),
      .nrst (nrst),
      .st   (st)
   );

   assign status_bits = {st.err_flag[2], st.busy_flag[2], st.err_flag[1],
                         st.busy_flag[1], st.err_flag[0], st.busy_flag[0]}; // RL19 RL20

   // ============================================================
   // access handling
   always_comb begin
      next_state     = state;
      next_state.ack = req;
      if (req && wr && slot_hit[4] && slot_hit[3:0] < 4'(NUM_CFG_SLOTS)) begin
         // unused slots and read-only words take no write
         if (addr[2]) begin
            next_state.cfg[slot_hit[3:0]][63:32] = wdata; // RL15
         end else begin
            next_state.cfg[slot_hit[3:0]][31:0] = wdata; // RL15
         end
      end
      if (req && !wr) begin
         if (addr == OFF_ARCH) begin
            next_state.rdata = ARCH_WORD; // RL1 RL2 RL3 RL4 RL5
         end else if (addr == OFF_COUNT) begin
            next_state.rdata = COUNT_WORD; // RL6 RL7
         end else if (addr == OFF_SUMMARY) begin
            next_state.rdata = summary[31:0]; // RL8 RL9
         end else if (addr == OFF_SUMMARY + HIGH_WORD) begin
            next_state.rdata = {8'h0, summary[55:32]}; // RL8
         end else if (addr == OFF_IDENTITY) begin
            next_state.rdata = ID_WORD; // RL11 RL12 RL13 RL14
         end else if (addr == OFF_IRQ_STATUS) begin
            next_state.rdata = {26'h0, status_bits}; // RL17 RL16
         end else if (addr == OFF_IRQ_STATUS + HIGH_WORD) begin
            next_state.rdata = 32'h0; // RL17
         end else if (slot_hit[4] && slot_hit[3:0] < 4'(NUM_CFG_SLOTS)) begin
            next_state.rdata = addr[2] ? state.cfg[slot_hit[3:0]][63:32]
                                       : state.cfg[slot_hit[3:0]][31:0]; // RL16
         end else begin
            next_state.rdata = 32'h0; // RL22 RL15
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= '{cfg: {NUM_CFG_SLOTS{CFG_RESET}}, rdata: RDATA_RESET, ack: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign ack        = state.ack;
   assign rdata      = state.rdata;
   assign irq_config = state.cfg;

   // ============================================================
   // checks
   sequence read_of(logic [11:0] a);
      req && !wr && addr == a;
   endsequence

   sequence write_of(logic [11:0] a);
      req && wr && addr == a;
   endsequence

   a_arch_word: assert property (@(posedge mclk) disable iff (!nrst) // RL1
      read_of(OFF_ARCH) |=> ack && rdata[ARCH_PRESENT_BIT] && rdata[15:12] == ARCH_VERSION)
      else $error("architecture word wrong");
   a_arch_fields: assert property (@(posedge mclk) disable iff (!nrst) // RL2
      read_of(OFF_ARCH) |=> rdata[31:ARCH_ARCHITECT_LSB] == ARCHITECT
                            && rdata[11:0] == ARCH_PART)
      else $error("architect or part field wrong");
   a_arch_rev: assert property (@(posedge mclk) disable iff (!nrst) // RL4
      read_of(OFF_ARCH) |=> rdata[19:ARCH_REVISION_LSB] <= REV_V11)
      else $error("reserved revision read");
   a_count_word: assert property (@(posedge mclk) disable iff (!nrst) // RL6
      read_of(OFF_COUNT) |=> rdata[31:16] == 16'h0 && rdata[15:0] <= 16'(MAX_RECORDS))
      else $error("record count word wrong");
   a_summary_lo: assert property (@(posedge mclk) disable iff (!nrst) // RL9
      read_of(OFF_SUMMARY) |=> rdata == $past(record_valid[31:0] & REPORT_MASK[31:0]))
      else $error("summary low word does not mirror valid bits");
   a_summary_hi: assert property (@(posedge mclk) disable iff (!nrst) // RL8
      read_of(OFF_SUMMARY + HIGH_WORD) |=> rdata[31:24] == 8'h0
         && rdata[23:0] == $past(record_valid[55:32] & REPORT_MASK[55:32]))
      else $error("summary high word wrong");
   a_identity: assert property (@(posedge mclk) disable iff (!nrst) // RL14
      read_of(OFF_IDENTITY) |=> !rdata[7] && rdata[31:ID_PART_LSB] == (ID_PRESENT ?
                                PART_NUMBER : 12'h0))
      else $error("identity word wrong");
   a_ro_ignored: assert property (@(posedge mclk) disable iff (!nrst) // RL22
      write_of(OFF_ARCH) |=> state.cfg == $past(state.cfg))
      else $error("read-only write changed state");
   a_slot_rw: assert property (@(posedge mclk) disable iff (!nrst) // RL15
      write_of(OFF_SLOT_BASE + 12'(2 * SLOT_STRIDE)) ##1 !req ##1 read_of(OFF_SLOT_BASE
         + 12'(2 * SLOT_STRIDE)) |=> rdata == $past(wdata, 3))
      else $error("config slot does not hold written data");
   a_status_top: assert property (@(posedge mclk) disable iff (!nrst) // RL17
      read_of(OFF_IRQ_STATUS) |=> rdata[31:STATUS_USED_BITS] == 26'h0)
      else $error("reserved status bits nonzero");
   a_busy_flag: assert property (@(posedge mclk) disable iff (!nrst) // RL19
      irq_write_busy[IRQ_FAULT] ##1 read_of(OFF_IRQ_STATUS)
         |=> rdata[2*IRQ_FAULT])
      else $error("busy flag not shown");
   a_err_clear: assert property (@(posedge mclk) disable iff (!nrst) // RL18
      (req && wr && addr == OFF_IRQ_STATUS && wdata[2*IRQ_FAULT+1]
         && !irq_write_error[IRQ_FAULT]) ##1 !irq_write_error[IRQ_FAULT]
         ##1 read_of(OFF_IRQ_STATUS) |=> !rdata[2*IRQ_FAULT+1])
      else $error("error flag not cleared by one");
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench for the error group register bank
// Assumes: one access at a time, ack exactly one cycle after req
// Notes:   identity and architecture codes below are arbitrary values
module tb;
   import error_group_pkg::*;
   // ==========================================================
   // parameters and signals
   localparam logic [10:0] P_ARCHITECT = 11'h02a;   // arbitrary value
   localparam logic [11:0] P_PART      = 12'h0c3;   // arbitrary value
   localparam logic [11:0] P_PARTNUM   = 12'h456;   // arbitrary value
   localparam logic [3:0]  P_BANK      = 4'h3;      // arbitrary value
   localparam logic [6:0]  P_CODE      = 7'h19;     // arbitrary value
   localparam logic [3:0]  P_MAJOR     = 4'h2;
   localparam logic [3:0]  P_MINOR     = 4'h0;
   localparam int          P_NREC      = 40;
   localparam logic [55:0] P_MASK      = 56'hff_ffff_ffff_f0ff;
   logic         mclk;
   logic         nrst;
   logic         req;
   logic         wr;
   logic [11:0]  addr;
   logic [31:0]  wdata;
   logic         ack;
   logic [31:0]  rdata;
   logic [55:0]  record_valid;
   logic [2:0]   irq_write_busy;
   logic [2:0]   irq_write_error;
   logic [383:0] irq_config;
   int           fail_count;
   int           checks;
   int           cycles;
   logic [31:0]  rd;

   `define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
      $display("ERROR %0t mismatch got %h exp %h", $time, a, b); end end

   error_group_regs #(.NUM_RECORDS(P_NREC), .SUMMARY_MASK(P_MASK), .ARCH_REVISION(REV_V11),
      .ARCHITECT(P_ARCHITECT), .ARCH_PART(P_PART), .ID_PRESENT(1'b1),
      .PART_NUMBER(P_PARTNUM), .ID_MAJOR(P_MAJOR), .ID_MINOR(P_MINOR),
      .MAKER_BANK(P_BANK), .MAKER_CODE(P_CODE)) error_group_regs_inst (
      .mclk(mclk), .nrst(nrst), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
      .ack(ack), .rdata(rdata), .record_valid(record_valid),
      .irq_write_busy(irq_write_busy), .irq_write_error(irq_write_error),
      .irq_config(irq_config));

   // ==========================================================
   // clock, timeout and bus tasks
   always #2 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge mclk);
      req   <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      req <= 1'b0;
      #1;
      `CHK(ack, 1'b1)
      r = rdata;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, rd);
      `CHK(rd, e)
   endtask

   task automatic err_pulse(input logic [2:0] v);
      @(posedge mclk);
      irq_write_error <= v;
      @(posedge mclk);
      irq_write_error <= 3'h0;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_discovery();
      logic [31:0] arch;
      arch = {P_ARCHITECT, 1'b1, REV_V11, ARCH_VERSION, P_PART};
      rd_chk(OFF_ARCH, arch);
      acc(1'b1, OFF_ARCH, 32'hffff_ffff, rd);
      rd_chk(OFF_ARCH, arch);
      `CHK(rd[20], 1'b1)
      `CHK(rd[19:16], REV_V11)
      `CHK(rd[15:12], 4'h0)
      rd_chk(OFF_COUNT, {16'h0, 16'(P_NREC)});
      `CHK(rd[15:0] <= 16'd56, 1'b1)
      rd_chk(OFF_IDENTITY, {P_PARTNUM, P_MAJOR, P_MINOR, P_BANK, 1'b0, P_CODE});
      `CHK(rd[7], 1'b0)
      acc(1'b1, OFF_IDENTITY, 32'hffff_ffff, rd);
      rd_chk(OFF_IDENTITY, {P_PARTNUM, P_MAJOR, P_MINOR, P_BANK, 1'b0, P_CODE});
      rd_chk(12'h100, 32'h0);
   endtask

   task automatic t_summary(input logic [55:0] v);
      logic [55:0] e;
      @(posedge mclk);
      record_valid <= v;
      for (int i = 0; i < 56; i++) begin
         e[i] = v[i] & P_MASK[i] & (i < P_NREC);
      end
      rd_chk(OFF_SUMMARY, e[31:0]);
      rd_chk(OFF_SUMMARY + HIGH_WORD, {8'h0, e[55:32]});
      acc(1'b1, OFF_SUMMARY, 32'hffff_ffff, rd);
      rd_chk(OFF_SUMMARY, e[31:0]);
   endtask

   task automatic t_slots();
      logic [11:0] a;
      for (int n = 0; n < 15; n++) begin
         a = OFF_SLOT_BASE + 12'(SLOT_STRIDE * n);
         acc(1'b1, a, 32'ha500_0000 | n, rd);
         acc(1'b1, a + HIGH_WORD, 32'h5a00_0000 | n, rd);
      end
      for (int n = 0; n < 15; n++) begin
         a = OFF_SLOT_BASE + 12'(SLOT_STRIDE * n);
         rd_chk(a, (n < 6) ? (32'ha500_0000 | n) : 32'h0);
         rd_chk(a + HIGH_WORD, (n < 6) ? (32'h5a00_0000 | n) : 32'h0);
         if (n < 6) begin
            `CHK(irq_config[64*n +: 64], {32'h5a00_0000 | n, 32'ha500_0000 | n})
         end
      end
      // write then read back with one idle cycle between
      acc(1'b1, OFF_SLOT_BASE + 12'h010, 32'hc3c3_0002, rd);
      rd_chk(OFF_SLOT_BASE + 12'h010, 32'hc3c3_0002);
   endtask

   task automatic t_status();
      @(posedge mclk);
      irq_write_busy <= 3'b101;
      err_pulse(3'b111);
      rd_chk(OFF_IRQ_STATUS, {26'h0, 6'b111011});
      rd_chk(OFF_IRQ_STATUS + HIGH_WORD, 32'h0);
      acc(1'b1, OFF_IRQ_STATUS, 32'h0000_0015, rd);
      rd_chk(OFF_IRQ_STATUS, {26'h0, 6'b111011});
      // error pulse on the clearing edge must keep the flag set
      @(posedge mclk);
      req             <= 1'b1;
      wr              <= 1'b1;
      addr            <= OFF_IRQ_STATUS;
      wdata           <= 32'h2;
      irq_write_error <= 3'b001;
      @(posedge mclk);
      req             <= 1'b0;
      irq_write_error <= 3'h0;
      rd_chk(OFF_IRQ_STATUS, {26'h0, 6'b111011});
      acc(1'b1, OFF_IRQ_STATUS, 32'h2, rd);
      rd_chk(OFF_IRQ_STATUS, {26'h0, 6'b111001});
      acc(1'b1, OFF_IRQ_STATUS, 32'h28, rd);
      rd_chk(OFF_IRQ_STATUS, {26'h0, 6'b010001});
      @(posedge mclk);
      irq_write_busy <= 3'b000;
      repeat (2) @(posedge mclk);
      rd_chk(OFF_IRQ_STATUS, 32'h0);
   endtask

   // mid-run reset must clear sticky flags and slots
   task automatic t_reset();
      err_pulse(3'b111);
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      `CHK(irq_config, 384'h0)
      rd_chk(OFF_IRQ_STATUS, 32'h0);
   endtask

   // ==========================================================
   // closing report
   task automatic end_of_test();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      req = 1'b0;
      wr = 1'b0;
      addr = 12'h0;
      wdata = 32'h0;
      record_valid = 56'h0;
      irq_write_busy = 3'h0;
      irq_write_error = 3'h0;
      fail_count = 0;
      checks = 0;
      cycles = 0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      `CHK(irq_config, 384'h0)
      `CHK(ack, 1'b0)
      t_discovery();
      t_summary(56'hff_ffff_ffff_ffff);
      t_summary(56'ha5_5a5a_c3c3_0f0f);
      t_slots();
      t_status();
      t_reset();
      end_of_test();
   end
endmodule
